// file: pre_top.sv
// Pulse rate estimator: presets, grouping, division, stop prediction
`include "pre_cfg.svh"
module pre_top import pre_pkg::*; #(
   parameter int CYC_PER_MS = `PRE_CYC_PER_MS
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic signed [11:0] sample,
   input  wire logic               cfg_load,
   input  wire logic        [3:0]  cfg_preset,
   input  wire logic        [2:0]  cfg_func,
   input  wire logic        [2:0]  cfg_range,
   input  wire logic               cfg_probe10,
   input  wire logic               cfg_coupling_ac,
   input  wire logic signed [7:0]  cfg_thr_pct,
   input  wire logic        [1:0]  cfg_hys,
   input  wire logic               cfg_slope_fall,
   input  wire logic        [9:0]  cfg_chat_ms,
   input  wire logic        [2:0]  cfg_bw,
   input  wire logic               cfg_pullup,
   input  wire logic        [12:0] cfg_group,
   input  wire logic               cfg_decel_en,
   input  wire logic        [3:0]  cfg_stop_mult,
   output logic                    meas_valid,
   output logic             [31:0] meas_freq,
   output logic             [39:0] meas_period,
   output logic                    decel_active,
   output logic                    stopped,
   output logic                    pullup_en,
   output logic             [2:0]  range_sel,
   output logic                    probe10,
   output logic                    coupling_ac,
   output logic signed      [7:0]  thr_pct,
   output logic             [2:0]  bw_sel,
   output logic                    bw_reject,
   output logic                    over_range_led
);
   typedef struct packed {
      pre_preset_t        preset;
      logic [2:0]         rng;
      logic               p10;
      logic               ac;
      logic signed [7:0]  thr;
      logic [5:0]         hys;
      logic               fall;
      logic [9:0]         chat;
      logic [2:0]         bw;
      logic               bw_rej;
      logic               pull;
      logic [12:0]        gsize;
      logic               dec_en;
      logic [3:0]         smult;
      logic               led;
      logic               seen;
      logic [39:0]        tick;
      logic [39:0]        gtime;
      logic [12:0]        gcnt;
      logic [39:0]        per;
      pre_phase_t         ph;
      logic [39:0]        dv_rem;
      logic [39:0]        dv_q;
      logic [39:0]        dv_d;
      logic [5:0]         dv_cnt;
      logic               dec;
      logic               stop;
      logic               valid;
      logic [31:0]        freq;
      logic [39:0]        operiod;
   } pre_st_t;

   pre_st_t     s;
   pre_st_t     next_s;
   pre_cond_if  cif ();
   logic [39:0] rem;
   logic [39:0] q;
   logic [39:0] stop_lim;
   logic [39:0] gt_sum;
   logic [12:0] gc_sum;
   logic [11:0] mag;

   pre_conditioner #(.CYC_PER_MS(CYC_PER_MS)) u_cond (
      .clk (clk),
      .rst (rst),
      .cif (cif.cond)
   );

   assign cif.sample     = sample;
   assign cif.thr_cnt    = 12'(s.thr) * `PRE_PCT_CNT;
   assign cif.hys_cnt    = s.hys;
   assign cif.slope_fall = s.fall;
   assign cif.chat_ms    = s.chat;

   always_comb begin
      next_s = s;
      next_s.valid = 1'b0;
      rem = '0;
      q = '0;
      gt_sum = s.gtime + s.tick;
      gc_sum = s.gcnt + 13'h1;
      // ****************************************
      // Configuration and presets
      // ****************************************
      if (cfg_load) begin
         next_s.preset = pre_preset_t'(cfg_preset);
         next_s.rng = (cfg_range > `PRE_RNG_MAX) ? `PRE_RNG_MAX : cfg_range;
         next_s.p10 = cfg_probe10; // R19
         next_s.ac = cfg_coupling_ac;
         // Threshold clipped to full scale
         if (cfg_thr_pct > `PRE_PCT_MAX) begin // R8
            next_s.thr = `PRE_PCT_MAX;
         end else if (cfg_thr_pct < -`PRE_PCT_MAX) begin
            next_s.thr = -`PRE_PCT_MAX;
         end else begin
            next_s.thr = cfg_thr_pct;
         end
         case (cfg_hys) // R9
            2'h0:    next_s.hys = `PRE_HYS_1P0;
            2'h1:    next_s.hys = `PRE_HYS_2P5;
            default: next_s.hys = `PRE_HYS_5P0;
         endcase
         next_s.fall = cfg_slope_fall;
         next_s.chat = (cfg_chat_ms > `PRE_CHAT_MAX_MS) ?
                       `PRE_CHAT_MAX_MS : cfg_chat_ms;
         next_s.dec_en = cfg_decel_en;
         next_s.smult = (cfg_stop_mult > `PRE_STOP_MAX) ?
                        `PRE_STOP_MAX : cfg_stop_mult;
         // Duty and width always measure single pulses
         if (cfg_func == PRE_F_DUTY || cfg_func == PRE_F_WIDTH) begin // R3
            next_s.gsize = 13'h1;
         end else if (cfg_group == 13'h0) begin // R1
            next_s.gsize = 13'h1;
         end else begin
            next_s.gsize = (cfg_group > `PRE_GROUP_MAX) ?
                           `PRE_GROUP_MAX : cfg_group;
         end
         next_s.pull = (pre_preset_t'(cfg_preset) == PRE_P_OPEN_COLLECTOR)
                       ? cfg_pullup : 1'b0; // R14
         next_s.bw = (cfg_bw > 3'(PRE_BW_FULL)) ? 3'(PRE_BW_FULL) : cfg_bw;
         next_s.bw_rej = 1'b0;
         case (pre_preset_t'(cfg_preset))
            PRE_P_LOGIC3: begin // R15
               next_s.rng = `PRE_RNG_5V;
               next_s.p10 = 1'b0;
               next_s.thr = `PRE_THR_L3;
            end
            PRE_P_LOGIC5: begin // R15
               next_s.rng = `PRE_RNG_5V;
               next_s.p10 = 1'b0;
               next_s.thr = `PRE_THR_L5;
            end
            PRE_P_LOGIC12: begin // R15
               next_s.rng = `PRE_RNG_20V;
               next_s.p10 = 1'b0;
               next_s.thr = `PRE_THR_L12;
            end
            PRE_P_LOGIC24: begin // R15
               next_s.rng = `PRE_RNG_50V;
               next_s.p10 = 1'b0;
               next_s.thr = `PRE_THR_L24;
            end
            PRE_P_ZERO_CROSSING: begin // R16
               next_s.ac = 1'b1;
               next_s.thr = 8'sh0;
            end
            PRE_P_AC100, PRE_P_AC200: begin
               next_s.p10 = 1'b1;
               next_s.ac = 1'b1;
               next_s.rng = (pre_preset_t'(cfg_preset) == PRE_P_AC100) ?
                            `PRE_RNG_20V : `PRE_RNG_50V;
               // Mains inputs must keep a band limit
               if (cfg_bw >= 3'(PRE_BW_FULL)) begin // R18
                  next_s.bw = 3'(PRE_BW_100K);
                  next_s.bw_rej = 1'b1;
               end
            end
            PRE_P_MAGNETIC_PICKUP: begin
               next_s.rng = `PRE_RNG_1V;
               next_s.thr = 8'sh0;
            end
            default: begin
            end
         endcase
      end
      // Indicator lit above full scale, except for pickups
      mag = sample[11] ? 12'(-sample) : 12'(sample);
      next_s.led = (mag > 12'(`PRE_FS_CNT)) &&
                   (s.preset != PRE_P_MAGNETIC_PICKUP); // R17
      // ****************************************
      // Shared serial divider
      // ****************************************
      if (s.ph != PRE_PH_IDLE) begin
         rem = {s.dv_rem[38:0], s.dv_q[39]};
         q = {s.dv_q[38:0], 1'b0};
         if (rem >= s.dv_d) begin
            rem = rem - s.dv_d;
            q[0] = 1'b1;
         end
         next_s.dv_rem = rem;
         next_s.dv_q = q;
         next_s.dv_cnt = s.dv_cnt - 6'h1;
         if (s.dv_cnt == 6'h0) begin
            next_s.ph = PRE_PH_IDLE;
            case (s.ph)
               PRE_PH_AVG: begin
                  // Per-pulse period feeds the reciprocal
                  next_s.per = q; // R2 R21
                  next_s.operiod = q;
                  next_s.ph = PRE_PH_FRQ;
                  next_s.dv_rem = '0;
                  next_s.dv_q = `PRE_FREQ_NUM;
                  next_s.dv_d = (q == 40'h0) ? 40'h1 : q;
                  next_s.dv_cnt = `PRE_DIV_STEPS;
               end
               PRE_PH_FRQ: begin
                  next_s.freq = q[31:0]; // R20
                  next_s.valid = 1'b1;
               end
               PRE_PH_DEC: begin
                  if (s.dec && !s.stop) begin
                     next_s.freq = q[31:0]; // R4
                     next_s.valid = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
      // ****************************************
      // Deceleration and stop prediction
      // ****************************************
      case (s.smult)
         4'h0:    stop_lim = s.per + {1'b0, s.per[39:1]}; // R6
         default: stop_lim = 40'(s.per * 40'(s.smult + 4'h1));
      endcase
      if (s.tick != '1) begin
         next_s.tick = s.tick + 40'h1;
      end
      if (s.seen && s.dec_en && s.per != 40'h0) begin
         if (s.tick >= s.per) begin
            next_s.dec = 1'b1; // R5
         end
         if (s.tick >= stop_lim && !s.stop) begin
            next_s.stop = 1'b1; // R7
            next_s.freq = 32'h0;
            next_s.valid = 1'b1;
         end
         // Reciprocal of elapsed time, refreshed whenever idle
         if (s.dec && !s.stop && s.ph == PRE_PH_IDLE) begin
            next_s.ph = PRE_PH_DEC; // R4
            next_s.dv_rem = '0;
            next_s.dv_q = `PRE_FREQ_NUM;
            next_s.dv_d = s.tick;
            next_s.dv_cnt = `PRE_DIV_STEPS;
         end
      end
      // ****************************************
      // Active edges and grouping
      // ****************************************
      if (cif.edge_act) begin
         next_s.tick = 40'h1;
         next_s.dec = 1'b0; // R22
         next_s.stop = 1'b0;
         next_s.seen = 1'b1;
         if (s.ph == PRE_PH_DEC) begin
            next_s.ph = PRE_PH_IDLE; // R22
         end
         if (!s.seen) begin
            next_s.gtime = 40'h0;
            next_s.gcnt = 13'h0;
            next_s.freq = s.stop ? 32'h0 : s.freq;
         end else if (gc_sum >= s.gsize) begin
            // A group closing while a period or frequency divide runs is dropped
            next_s.gtime = 40'h0; // R1
            next_s.gcnt = 13'h0;
            if (s.ph == PRE_PH_IDLE || s.ph == PRE_PH_DEC) begin
               next_s.ph = PRE_PH_AVG; // R21
               next_s.dv_rem = '0;
               next_s.dv_q = gt_sum;
               next_s.dv_d = {27'h0, s.gsize};
               next_s.dv_cnt = `PRE_DIV_STEPS;
            end
         end else begin
            next_s.gtime = gt_sum;
            next_s.gcnt = gc_sum;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.preset <= PRE_P_USER;
         s.hys <= `PRE_HYS_1P0;
         s.bw <= 3'(PRE_BW_FULL);
         s.gsize <= `PRE_RST_GROUP;
         s.ph <= PRE_PH_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs, all registered
   // ****************************************
   assign meas_valid     = s.valid;
   assign meas_freq      = s.freq;
   assign meas_period    = s.operiod;
   assign decel_active   = s.dec;
   assign stopped        = s.stop;
   assign pullup_en      = s.pull;
   assign range_sel      = s.rng;
   assign probe10        = s.p10;
   assign coupling_ac    = s.ac;
   assign thr_pct        = s.thr;
   assign bw_sel         = s.bw;
   assign bw_reject      = s.bw_rej;
   assign over_range_led = s.led;
endmodule : pre_top

// file: pre_cfg.svh
// Constants for the pulse rate estimator
// Operation
// [R1] Group averaging collects 1 to 4096 pulses, one measurement per group.
// [R2] Averaged results are normalised to a single-pulse value.
// [R3] No averaging for duty cycle or pulse width.
// [R4] Decel frequency is reciprocal of time since last pulse.
// [R5] Deceleration starts one last period after the final pulse.
// [R6] Stop delay is 1.5 or 2 to 10 times the last period.
// [R7] Stop delay expiry without a pulse forces frequency to zero.
// [R8] Threshold settable within full scale in 1 % steps.
// [R9] Hysteresis is plus or minus 1, 2.5 or 5 % of full scale.
// [R10] Active edge is selectable as rising or falling.
// [R11] Chatter filter ignores changes for 0 to 1000 ms after a change.
// [R12] A chatter interval of zero disables the filter.
// [R13] Chatter filter acts after both rising and falling changes.
// [R14] Pull-up enable only under open-collector preset, else forced off.
// [R15] Logic presets pick optimum range and threshold at half supply.
// [R16] Zero-crossing preset forces AC coupling and zero threshold.
// [R17] Magnetic-pickup preset keeps the over-range indicator dark.
// [R18] Full bandwidth refused under mains presets.
// [R19] Six ranges 1..50 V at 1:1, ten times larger at 10:1.
// [R20] Frequency is reciprocal of interval between successive active edges.
// [R21] Group period is total group time divided by group size.
// [R22] A new active edge cancels deceleration or stop at once.
`ifndef PRE_CFG_SVH
`define PRE_CFG_SVH
// ****************************************
// Timing
// ****************************************
`define PRE_CLK_NS      10
`define PRE_MS_NS       1000000
`define PRE_CYC_PER_MS  (`PRE_MS_NS / `PRE_CLK_NS)
// Frequency reported in 0.01 Hz units
`define PRE_FREQ_NUM    40'(64'd100000000000 / 64'(`PRE_CLK_NS))
`define PRE_CHAT_MAX_MS 10'd1000
`define PRE_GROUP_MAX   13'd4096
`define PRE_DIV_STEPS   6'd39
// ****************************************
// Analog scale: full scale is 1000 counts
// ****************************************
`define PRE_FS_CNT      12'sd1000
`define PRE_PCT_CNT     12'sd10
`define PRE_PCT_MAX     8'sd100
`define PRE_HYS_1P0     6'd10
`define PRE_HYS_2P5     6'd25
`define PRE_HYS_5P0     6'd50
// ****************************************
// Range indices and preset values
// ****************************************
`define PRE_RNG_1V      3'd0
`define PRE_RNG_5V      3'd2
`define PRE_RNG_20V     3'd4
`define PRE_RNG_50V     3'd5
`define PRE_RNG_MAX     3'd5
`define PRE_THR_L3      8'sd30
`define PRE_THR_L5      8'sd50
`define PRE_THR_L12     8'sd30
`define PRE_THR_L24     8'sd24
`define PRE_STOP_MAX    4'd9
`define PRE_RST_GROUP   13'd1
`endif

// file: pre_pkg.sv
// Types for the pulse rate estimator
package pre_pkg;
   typedef enum logic [2:0] {
      PRE_F_FREQ, PRE_F_REV, PRE_F_PERIOD, PRE_F_DUTY,
      PRE_F_POWER, PRE_F_WIDTH, PRE_F_INTEG, PRE_F_VELOC
   } pre_func_t;
   typedef enum logic [3:0] {
      PRE_P_USER, PRE_P_LOGIC3, PRE_P_LOGIC5, PRE_P_LOGIC12,
      PRE_P_LOGIC24, PRE_P_OPEN_COLLECTOR, PRE_P_ZERO_CROSSING,
      PRE_P_AC100, PRE_P_AC200, PRE_P_MAGNETIC_PICKUP
   } pre_preset_t;
   typedef enum logic [2:0] {
      PRE_BW_100, PRE_BW_1K, PRE_BW_10K, PRE_BW_100K, PRE_BW_FULL
   } pre_bw_t;
   typedef enum logic [3:0] {
      PRE_PH_IDLE = 4'b0001,
      PRE_PH_AVG  = 4'b0010,
      PRE_PH_FRQ  = 4'b0100,
      PRE_PH_DEC  = 4'b1000
   } pre_phase_t;
endpackage : pre_pkg

// file: pre_cond_if.sv
// Comparator and chatter filter control bundle
interface pre_cond_if;
   logic signed [11:0] sample;
   logic signed [11:0] thr_cnt;
   logic        [5:0]  hys_cnt;
   logic               slope_fall;
   logic        [9:0]  chat_ms;
   logic               edge_act;
   modport cond (input sample, thr_cnt, hys_cnt, slope_fall, chat_ms,
                 output edge_act);
   modport ctl  (output sample, thr_cnt, hys_cnt, slope_fall, chat_ms,
                 input edge_act);
endinterface : pre_cond_if

// file: pre_conditioner.sv
// Hysteresis comparator, chatter filter and active edge detector
`include "pre_cfg.svh"
module pre_conditioner import pre_pkg::*; #(
   parameter int CYC_PER_MS = `PRE_CYC_PER_MS
) (
   input  wire logic clk,
   input  wire logic rst,
   pre_cond_if.cond  cif
);
   typedef struct packed {
      logic        level;
      logic        blk;
      logic [16:0] pre;
      logic [9:0]  ms;
      logic        edge_act;
   } pre_cond_st_t;

   pre_cond_st_t s;
   pre_cond_st_t next_s;
   logic signed [12:0] hi_lim;
   logic signed [12:0] lo_lim;
   logic               comp;

   always_comb begin
      next_s = s;
      next_s.edge_act = 1'b0;
      hi_lim = 13'(cif.thr_cnt) + 13'(signed'({1'b0, cif.hys_cnt}));
      lo_lim = 13'(cif.thr_cnt) - 13'(signed'({1'b0, cif.hys_cnt}));
      // Inside the band the previous decision holds
      if (13'(cif.sample) > hi_lim) begin // R8 R9
         comp = 1'b1;
      end else if (13'(cif.sample) < lo_lim) begin
         comp = 1'b0;
      end else begin
         comp = s.level;
      end
      if (s.blk) begin
         if (s.pre == 17'(CYC_PER_MS - 1)) begin
            next_s.pre = 17'h0;
            next_s.ms = s.ms + 10'h1;
            if (s.ms + 10'h1 >= cif.chat_ms) begin // R11
               next_s.blk = 1'b0;
            end
         end else begin
            next_s.pre = s.pre + 17'h1;
         end
      end else if (comp != s.level) begin
         // Both directions start the hold-off window
         next_s.level = comp; // R13
         next_s.blk = (cif.chat_ms != 10'h0); // R12
         next_s.pre = 17'h0;
         next_s.ms = 10'h0;
         next_s.edge_act = (comp != cif.slope_fall); // R10
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign cif.edge_act = s.edge_act;
endmodule : pre_conditioner

// file: pre_sensor_model.sv
// Pulse sensor model driving the conditioned input sample
module pre_sensor_model (
   input  wire logic               clk,
   input  wire logic               run,
   input  wire logic               bounce,
   input  wire logic        [15:0] per,
   input  wire logic signed [11:0] amp,
   output logic signed      [11:0] sample
);
   timeunit 1ns;
   timeprecision 100ps;
   // *****
   // Square wave with optional contact bounce
   // *****
   logic [15:0] cnt;
   logic [15:0] half;
   logic [15:0] ph;
   logic        glitch;
   assign half = per >> 1;
   assign ph = cnt % half;
   // Bounce lands 50 cycles before the end of each half
   assign glitch = bounce && ph >= half - 16'h32 && ph < half - 16'h2f;
   // A stopped sensor sits low
   always @(negedge clk) begin
      sample <= (run && ((cnt < half) ^ glitch)) ? amp : -amp;
      cnt <= (!run || cnt == per - 16'h1) ? 16'h0 : cnt + 16'h1;
   end
endmodule : pre_sensor_model

// file: pre_monitor.sv
// Port checker for the pulse rate estimator
module pre_monitor #(
   parameter int CYC_PER_MS = 100000
) (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic signed [11:0] sample,
   input wire logic               cfg_load,
   input wire logic        [3:0]  cfg_preset,
   input wire logic        [2:0]  cfg_range,
   input wire logic signed [7:0]  cfg_thr_pct,
   input wire logic        [2:0]  cfg_bw,
   input wire logic               cfg_pullup,
   input wire logic        [31:0] meas_freq,
   input wire logic               decel_active,
   input wire logic               stopped,
   input wire logic               pullup_en,
   input wire logic        [2:0]  range_sel,
   input wire logic               coupling_ac,
   input wire logic signed [7:0]  thr_pct,
   input wire logic        [2:0]  bw_sel,
   input wire logic               bw_reject,
   input wire logic               over_range_led
);
   timeunit 1ns;
   timeprecision 100ps;
   // *****
   // Checks
   // *****
   logic [3:0] cur_preset;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Latched preset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_preset <= 4'h0;
      end else if (cfg_load) begin
         cur_preset <= cfg_preset;
      end
   end
   AST_STOP_ZERO: assert property (stopped |-> meas_freq == 32'h0)
      else $error("freq nonzero while stopped");
   AST_PULLUP_LOCK: assert property (
      cfg_load && cfg_preset != 4'h5 |=> !pullup_en)
      else $error("pull-up on outside its preset");
   AST_PULLUP_SET: assert property (
      cfg_load && cfg_preset == 4'h5 && cfg_pullup |=> pullup_en)
      else $error("pull-up request lost");
   AST_BW_REJECT: assert property (
      cfg_load && cfg_preset inside {4'h7, 4'h8} && cfg_bw >= 3'h4
      |=> bw_sel == 3'h3 && bw_reject)
      else $error("full band kept on mains");
   AST_ZERO_CROSS: assert property (
      cfg_load && cfg_preset == 4'h6 ##1 1'b1 |-> coupling_ac && thr_pct == 0)
      else $error("zero crossing not applied");
   AST_LOGIC5: assert property (
      cfg_load && cfg_preset == 4'h2 |=> range_sel == 3'h2 && thr_pct == 50)
      else $error("logic preset wrong");
   AST_RANGE_CAP: assert property (
      cfg_load && cfg_preset == 4'h0 && cfg_range > 3'h5 |=> range_sel == 3'h5)
      else $error("range not clipped");
   AST_THR_CLIP: assert property (
      cfg_load && cfg_preset == 4'h0 && cfg_thr_pct > 8'sd100
      |=> thr_pct == 8'sd100)
      else $error("threshold not clipped");
   AST_LED_DARK: assert property (
      cur_preset == 4'h9 && !cfg_load |=> !over_range_led)
      else $error("over-range lit for pickup");
   AST_LED_LIT: assert property (
      cur_preset != 4'h9 && !cfg_load
      && (sample > 12'sd1000 || sample < -12'sd1000) |=> over_range_led)
      else $error("over-range not lit");
   cover property ($rose(decel_active));
   cover property ($rose(stopped));
   cover property ($rose(bw_reject));
endmodule : pre_monitor

bind pre_top pre_monitor #(.CYC_PER_MS(CYC_PER_MS)) pre_monitor_inst (
   .clk, .rst, .sample, .cfg_load, .cfg_preset, .cfg_range, .cfg_thr_pct,
   .cfg_bw, .cfg_pullup, .meas_freq, .decel_active, .stopped, .pullup_en,
   .range_sel, .coupling_ac, .thr_pct, .bw_sel, .bw_reject, .over_range_led
);

// file: tb_top.sv
// Self-checking bench for the pulse rate estimator
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic               clk, rst, cfg_load, cfg_probe10, cfg_coupling_ac;
   logic               cfg_slope_fall, cfg_pullup, cfg_decel_en, run, bounce;
   logic               meas_valid, decel_active, stopped, pullup_en;
   logic               probe10, coupling_ac, bw_reject, over_range_led;
   logic signed [11:0] sample, amp;
   logic signed [7:0]  cfg_thr_pct, thr_pct;
   logic        [3:0]  cfg_preset, cfg_stop_mult;
   logic        [2:0]  cfg_func, cfg_range, cfg_bw, range_sel, bw_sel;
   logic        [1:0]  cfg_hys;
   logic        [9:0]  cfg_chat_ms;
   logic        [12:0] cfg_group;
   logic        [15:0] per;
   logic        [31:0] meas_freq;
   logic        [39:0] meas_period;
   int                 n_fail, n_checks, t, d;
   // 10 cycles per ms keeps chatter runs short
   pre_top #(.CYC_PER_MS(10)) pre_top_inst (.*);
   pre_sensor_model pre_sensor_model_inst (.clk, .run, .bounce, .per, .amp,
                                           .sample);
   // *****
   // Tasks
   // *****
   task automatic chk(input string what, input logic [39:0] e,
                      input logic [39:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", what, e, g);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic load;
      @(negedge clk);
      cfg_load = 1'b1;
      @(negedge clk);
      cfg_load = 1'b0;
      @(negedge clk);
   endtask : load
   // 0 decel, 1 stop, 2 clear, 3 result
   task automatic wait_until(input int w, input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (!(w == 0 ? decel_active === 1'b1 : w == 1 ? stopped === 1'b1
               : w == 2 ? decel_active === 1'b0 && stopped === 1'b0
               : meas_valid === 1'b1) && n < lim);
      @(negedge clk);
   endtask : wait_until
   task automatic start(input int p);
      run = 1'b0;
      repeat (200) @(negedge clk);
      load;
      per = p[15:0];
      run = 1'b1;
   endtask : start
   task automatic meas(input int p, input int sp);
      int n;
      wait_until(3, 5000, n);
      wait_until(3, 5000, n);
      chk("spacing", sp, n);
      chk("period", p, meas_period);
      chk("freq", 64'd10000000000 / p, meas_freq);
   endtask : meas
   task automatic pchk(input logic [3:0] p, input logic [2:0] r,
                       input logic signed [7:0] th, input logic [1:0] pa,
                       input logic [3:0] m);
      cfg_preset = p;
      load;
      if (m[0]) chk("range", r, range_sel);
      if (m[1]) chk("thr", th, thr_pct);
      if (m[2]) chk("probe", pa[1], probe10);
      if (m[3]) chk("coupling", pa[0], coupling_ac);
   endtask : pchk
   task automatic hchk(input logic signed [11:0] a,
                       input logic signed [7:0] th, input logic [1:0] h,
                       input logic e);
      int n;
      cfg_thr_pct = th;
      cfg_hys = h;
      amp = a;
      start(200);
      n = 0;
      repeat (1200) begin
         @(posedge clk);
         #1;
         if (meas_valid === 1'b1) n++;
      end
      @(negedge clk);
      chk("edges_seen", e, n > 0);
   endtask : hchk
   // *****
   // Stimulus
   // *****
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      stop_test;
   end
   initial begin
      {rst, cfg_load, cfg_probe10, cfg_coupling_ac, cfg_slope_fall} = 5'h16;
      {cfg_decel_en, run, bounce, cfg_stop_mult, cfg_func, cfg_hys} = 12'h0;
      {cfg_preset, cfg_chat_ms} = 14'h0;
      {cfg_range, cfg_bw, cfg_pullup} = 7'h7f;
      cfg_thr_pct = 8'sd120;
      cfg_group = 13'h1;
      per = 16'd1000;
      amp = 12'sd1500;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      pchk(4'h0, 3'h5, 8'sd100, 2'h3, 4'hf);
      chk("bw_user", 3'h4, bw_sel);
      chk("pullup_user", 0, pullup_en);
      repeat (3) @(negedge clk);
      chk("led_user", 1, over_range_led);
      pchk(4'h1, 3'h2, 8'sd30, 2'h0, 4'h3);
      pchk(4'h2, 3'h2, 8'sd50, 2'h0, 4'h3);
      pchk(4'h3, 3'h4, 8'sd30, 2'h0, 4'h3);
      pchk(4'h4, 3'h5, 8'sd24, 2'h0, 4'h3);
      pchk(4'h6, 3'h0, 8'sd0, 2'h1, 4'ha);
      pchk(4'h7, 3'h4, 8'sd0, 2'h3, 4'hd);
      chk("bw_mains", 3'h3, bw_sel);
      chk("bw_reject", 1, bw_reject);
      pchk(4'h8, 3'h5, 8'sd0, 2'h3, 4'hd);
      pchk(4'h5, 3'h0, 8'sd0, 2'h0, 4'h0);
      chk("pullup_oc", 1, pullup_en);
      pchk(4'h9, 3'h0, 8'sd0, 2'h0, 4'h3);
      repeat (3) @(negedge clk);
      chk("led_pickup", 0, over_range_led);
      $display("test presets done");
      {cfg_preset, cfg_thr_pct, cfg_bw} = 15'h3;
      amp = 12'sd500;
      start(1000);
      meas(1000, 1000);
      cfg_group = 13'h4;
      start(200);
      meas(200, 800);
      cfg_group = 13'h1;
      cfg_slope_fall = 1'b1;
      start(500);
      meas(500, 500);
      cfg_slope_fall = 1'b0;
      cfg_func = 3'h3;
      cfg_group = 13'h4;
      start(250);
      meas(250, 250);
      cfg_func = 3'h2;
      cfg_group = 13'h2;
      start(250);
      meas(250, 500);
      $display("test measurement done");
      cfg_func = 3'h0;
      cfg_group = 13'h1;
      cfg_chat_ms = 10'd18;
      bounce = 1'b1;
      start(400);
      meas(400, 400);
      cfg_chat_ms = 10'd0;
      start(400);
      wait_until(3, 5000, t);
      chk("filter_off", 1, meas_period != 40'd400);
      bounce = 1'b0;
      $display("test chatter done");
      hchk(12'sd30, 8'sd0, 2'h0, 1'b1);
      hchk(12'sd30, 8'sd0, 2'h1, 1'b1);
      hchk(12'sd20, 8'sd0, 2'h1, 1'b0);
      hchk(12'sd30, 8'sd0, 2'h2, 1'b0);
      hchk(12'sd45, 8'sd0, 2'h3, 1'b0);
      hchk(12'sd55, 8'sd5, 2'h0, 1'b0);
      hchk(12'sd70, 8'sd5, 2'h0, 1'b1);
      $display("test comparator done");
      {cfg_thr_pct, cfg_hys, amp} = {8'sd0, 2'h0, 12'sd500};
      cfg_decel_en = 1'b1;
      for (int m = 0; m < 10; m++) begin
         cfg_stop_mult = m[3:0];
         start(200);
         wait_until(3, 5000, t);
         wait_until(3, 5000, t);
         run = 1'b0;
         wait_until(0, 3000, t);
         wait_until(3, 300, d);
         chk("decel_freq", 1, meas_freq <= 32'd50000000 && meas_freq >= 32'd47619047);
         wait_until(1, 3000, t);
         d = d + t + 1;
         t = (m == 0) ? 100 : m * 200;
         chk("stop_delay", 1, d + 3 >= t && d <= t + 3);
         chk("stop_freq", 0, meas_freq);
         run = 1'b1;
         wait_until(2, 20, t);
         chk("resume", 1, t < 20);
      end
      $display("test deceleration done");
      stop_test;
   end
endmodule : tb_top
